// [design/egress_vc_pkg.sv]
// constants for the egress virtual-channel status and capability registers
`default_nettype none
package egress_vc_pkg;

    // =====================================================================
    // register offsets (byte addresses inside the egress port window)
    // =====================================================================
    localparam logic [11:0] VC0_STATUS_OFFSET  = 12'h01a;
    localparam logic [11:0] VC0_STATUS_DWORD   = 12'h018;
    localparam logic [11:0] VC1_CAP_OFFSET     = 12'h01c;
    localparam logic [11:0] VC1_CTL_OFFSET     = 12'h020;
    localparam int          ADDR_W             = 12;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int NEG_PENDING_BIT  = 1;
    localparam int TABLE_LOC_LSB    = 24;
    localparam int TSL_MSB          = 22;
    localparam int TSL_LSB          = 16;
    localparam int TSL_W            = 7;
    localparam int TSL_LANE         = 2;
    localparam int SNOOP_REJECT_BIT = 15;
    localparam int ENABLE_BIT       = 31;
    localparam int ENABLE_LANE      = 3;

    // =====================================================================
    // reset and fixed values
    // =====================================================================
    localparam logic [15:0] VC0_STATUS_RESET   = 16'h0000;
    localparam logic [7:0]  TABLE_LOC_VALUE    = 8'h10;
    localparam logic [6:0]  TSL_RESET          = 7'h00;
    localparam logic        SNOOP_REJECT_VALUE = 1'b1;
    localparam logic [7:0]  ARB_CAP_VALUE      = 8'h10;
    localparam logic [31:0] VC1_CAP_RESET      = 32'h10008010;
    localparam logic [31:0] VC1_CTL_RESET      = 32'h01080000;
    localparam int          ACK_LATENCY        = 1;

    // =====================================================================
    // helpers
    // =====================================================================
    function automatic logic lane_write(input logic wr, input logic [11:0] addr,
                                        input logic [3:0] be, input logic [11:0] target,
                                        input int lane);
        lane_write = wr && (addr == target) && be[lane];
    endfunction : lane_write

endpackage : egress_vc_pkg
`default_nettype wire

// [design/reg_wr_if.sv]
// register write strobe and data carried to the time slot field
`timescale 1ns/10ps
`default_nettype none
interface reg_wr_if;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;

    modport source (output wr, output addr, output be, output wdata);
    modport sink   (input wr, input addr, input be, input wdata);
endinterface : reg_wr_if
`default_nettype wire

// [design/negotiation_status.sv]
// channel zero negotiation-pending status flag
`timescale 1ns/10ps
`default_nettype none
module negotiation_status (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    // link state
    input  wire logic i_fc_init_in_progress,
    input  wire logic i_vc0_disable_in_progress,
    // status
    output logic      o_channel_zero_negotiation_pending
);
    logic pending_q;
    logic pending_d;

    // =====================================================================
    // flag follows the link's flow control initialisation or channel zero disable
    // =====================================================================
    always_comb begin
        pending_d = i_fc_init_in_progress | i_vc0_disable_in_progress; // [RULE_02] [RULE_03]
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d; // [RULE_01]
        end
    end

    assign o_channel_zero_negotiation_pending = pending_q;
endmodule : negotiation_status
`default_nettype wire

// [design/time_slot_field.sv]
// write-once time slot limit field of the channel one capability register
`timescale 1ns/10ps
`default_nettype none
module time_slot_field
    import egress_vc_pkg::*;
(
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    // register writes
    reg_wr_if.sink                wr_bus,
    // field
    output logic [TSL_W-1:0]      o_time_slot_limit,
    output logic                  o_locked
);
    logic [TSL_W-1:0] tsl_q;
    logic [TSL_W-1:0] tsl_d;
    logic             locked_q;
    logic             locked_d;

    // =====================================================================
    // one write only; later writes are dropped until reset
    // =====================================================================
    always_comb begin
        tsl_d    = tsl_q;
        locked_d = locked_q;
        if (!locked_q && lane_write(wr_bus.wr, wr_bus.addr, wr_bus.be,
                                    VC1_CAP_OFFSET, TSL_LANE)) begin
            tsl_d    = wr_bus.wdata[TSL_MSB:TSL_LSB]; // [RULE_07]
            locked_d = 1'b1; // [RULE_13]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tsl_q    <= TSL_RESET;
            locked_q <= 1'b0;
        end else begin
            tsl_q    <= tsl_d;
            locked_q <= locked_d;
        end
    end

    assign o_time_slot_limit = tsl_q;
    assign o_locked          = locked_q;
endmodule : time_slot_field
`default_nettype wire

// [design/egress_vc_status_capability_regs.sv]
// egress port channel zero status and channel one capability/control registers
//
// Summary of operation
// [RULE_01] Negotiation-pending bit reads zero once channel zero negotiation completes.
// [RULE_02] Pending bit stays one while channel zero initialises or disables.
// [RULE_03] For channel zero the pending bit mirrors flow control initialisation.
// [RULE_04] Software checks pending clear at both link ends before using a channel.
// [RULE_05] Status register: 16-bit, read only, resets zero, all but bit 1 reserved.
// [RULE_06] Capability bits 31:24 read fixed 10h, table location in 16-byte units.
// [RULE_07] Capability bits 22:16 hold time slots minus one, reset 00h, write once.
// [RULE_08] Init software picks time slot value from the maximum-slots register.
// [RULE_09] Snoop-reject bit set: channel one requests without No Snoop are unsupported.
// [RULE_10] Arbitration capability bits 7:0 read 10h, weighted round robin only.
// [RULE_11] Channel one control register is 32-bit and resets to 01080000h.
// [RULE_12] Enable bit 31 reads back what was written, changes no behaviour.
// [RULE_13] Writes to read-only, reserved or already-written fields are ignored.
`timescale 1ns/10ps
`default_nettype none
module egress_vc_status_capability_regs
    import egress_vc_pkg::*;
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_resetn,
    // register access, dword aligned byte address
    input  wire logic              i_reg_rd,
    input  wire logic              i_reg_wr,
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic [3:0]        i_reg_be,
    input  wire logic [31:0]       i_reg_wdata,
    output logic [31:0]            o_reg_rdata,
    output logic                   o_reg_ack,
    // link negotiation state
    input  wire logic              i_fc_init_in_progress,
    input  wire logic              i_vc0_disable_in_progress,
    output logic                   o_channel_zero_negotiation_pending,
    // channel one request screening
    input  wire logic              i_vc1_req_valid,
    input  wire logic              i_vc1_req_no_snoop,
    output logic                   o_vc1_unsupported_req,
    // time slot limit for the arbiter
    output logic [TSL_W-1:0]       o_time_slot_limit
);

    // =====================================================================
    // elaboration checks
    // =====================================================================
    // read packing below assumes these widths and ranges
    if (TSL_MSB - TSL_LSB + 1 != TSL_W) begin : g_bad_tsl
        $error("time slot width does not match its bit range");
    end
    if (ADDR_W < 6) begin : g_bad_addr
        $error("register address too narrow for the mapped offsets");
    end

    // =====================================================================
    // reset release
    // =====================================================================
    logic rst_meta_q;
    logic rst_n_sync;

    // assertion only removed after two clean edges to avoid a ragged release
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_sync <= rst_meta_q;
        end
    end

    // =====================================================================
    // write distribution
    // =====================================================================
    reg_wr_if wr_bus ();

    assign wr_bus.wr    = i_reg_wr;
    assign wr_bus.addr  = i_reg_addr;
    assign wr_bus.be    = i_reg_be;
    assign wr_bus.wdata = i_reg_wdata;

    // =====================================================================
    // sub-blocks
    // =====================================================================
    logic             pending;
    logic [TSL_W-1:0] tsl;
    logic             tsl_locked;

    negotiation_status u_negotiation (
        .i_sys_clk                          (i_sys_clk),
        .i_rst_n                            (rst_n_sync),
        .i_fc_init_in_progress              (i_fc_init_in_progress),
        .i_vc0_disable_in_progress          (i_vc0_disable_in_progress),
        .o_channel_zero_negotiation_pending (pending)
    );

    time_slot_field u_time_slot (
        .i_sys_clk         (i_sys_clk),
        .i_rst_n           (rst_n_sync),
        .wr_bus            (wr_bus),
        .o_time_slot_limit (tsl),
        .o_locked          (tsl_locked)
    );

    assign o_channel_zero_negotiation_pending = pending;
    assign o_time_slot_limit                  = tsl;

    // =====================================================================
    // channel one control: only the enable bit holds state
    // =====================================================================
    logic enable_q;
    logic enable_d;

    always_comb begin
        enable_d = enable_q;
        if (lane_write(i_reg_wr, i_reg_addr, i_reg_be, VC1_CTL_OFFSET, ENABLE_LANE)) begin
            enable_d = i_reg_wdata[ENABLE_BIT]; // [RULE_12]
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            enable_q <= VC1_CTL_RESET[ENABLE_BIT]; // [RULE_11]
        end else begin
            enable_q <= enable_d;
        end
    end

    // =====================================================================
    // read data assembly
    // =====================================================================
    logic [15:0] status_word;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;

    always_comb begin
        status_word                  = VC0_STATUS_RESET; // [RULE_05]
        status_word[NEG_PENDING_BIT] = pending; // [RULE_01]
    end

    // fixed fields are constants, so no write can reach them
    assign cap_word = {TABLE_LOC_VALUE,              // [RULE_06]
                       1'b0,
                       tsl,                          // [RULE_07]
                       SNOOP_REJECT_VALUE,
                       VC1_CAP_RESET[14:8],
                       ARB_CAP_VALUE};               // [RULE_10] [RULE_13]

    // enable bit has no consumer; layout of the rest is held at its reset value
    assign ctl_word = {enable_q, VC1_CTL_RESET[30:0]}; // [RULE_11] [RULE_12]

    // =====================================================================
    // access answer: one cycle after the strobe, unmapped reads zero
    // =====================================================================
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ack_q;
    logic        ack_d;

    always_comb begin
        ack_d   = i_reg_rd | i_reg_wr;
        rdata_d = rdata_q;
        if (i_reg_rd) begin
            // low half of this dword belongs to a neighbouring register
            if (i_reg_addr == VC0_STATUS_DWORD) begin
                rdata_d = {status_word, 16'h0000};
            end else if (i_reg_addr == VC1_CAP_OFFSET) begin
                rdata_d = cap_word;
            end else if (i_reg_addr == VC1_CTL_OFFSET) begin
                rdata_d = ctl_word;
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_reg_ack   = ack_q;

    // =====================================================================
    // snoop screening of channel one requests
    // =====================================================================
    logic ur_q;
    logic ur_d;

    always_comb begin
        ur_d = i_vc1_req_valid && !i_vc1_req_no_snoop && SNOOP_REJECT_VALUE; // [RULE_09]
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ur_q <= 1'b0;
        end else begin
            ur_q <= ur_d;
        end
    end

    assign o_vc1_unsupported_req = ur_q;

    // =====================================================================
    // checks
    // =====================================================================
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n_sync);

    pending_set_a: assert property ( // [RULE_02]
        (i_fc_init_in_progress || i_vc0_disable_in_progress) |=> pending
    ) else $error("pending bit not set during negotiation");

    pending_clear_a: assert property ( // [RULE_01]
        (!i_fc_init_in_progress && !i_vc0_disable_in_progress) |=> !pending
    ) else $error("pending bit not cleared after negotiation");

    pending_read_a: assert property ( // [RULE_03] [RULE_05]
        (i_reg_rd && i_reg_addr == VC0_STATUS_DWORD) |=>
            o_reg_ack && o_reg_rdata[17] == $past(pending) && o_reg_rdata[16] == 1'b0
            && o_reg_rdata[31:18] == 14'h0000
    ) else $error("status read wrong");

    cap_fixed_a: assert property ( // [RULE_06]
        (i_reg_rd && i_reg_addr == VC1_CAP_OFFSET) |=>
            o_reg_rdata[31:23] == {TABLE_LOC_VALUE, 1'b0} && o_reg_rdata[15:8] == 8'h80
    ) else $error("capability fixed fields wrong");

    arb_cap_a: assert property ( // [RULE_10]
        (i_reg_rd && i_reg_addr == VC1_CAP_OFFSET) |=> o_reg_rdata[7:0] == 8'h10
    ) else $error("arbitration capability wrong");

    slot_once_a: assert property ( // [RULE_13]
        (tsl_locked && i_reg_wr) |=> $stable(tsl) && tsl_locked
    ) else $error("time slot field changed after first write");

    slot_write_a: assert property ( // [RULE_07]
        (!tsl_locked && i_reg_wr && i_reg_addr == VC1_CAP_OFFSET && i_reg_be[2]) |=>
            tsl == $past(i_reg_wdata[22:16]) && tsl_locked
    ) else $error("first time slot write lost");

    snoop_reject_a: assert property ( // [RULE_09]
        (i_vc1_req_valid && !i_vc1_req_no_snoop) |=> o_vc1_unsupported_req
    ) else $error("snooped request not rejected");

    snoop_allow_a: assert property ( // [RULE_09]
        !(i_vc1_req_valid && !i_vc1_req_no_snoop) |=> !o_vc1_unsupported_req
    ) else $error("request rejected without cause");

    ctl_value_a: assert property ( // [RULE_11]
        (i_reg_rd && i_reg_addr == VC1_CTL_OFFSET) |=>
            o_reg_rdata[30:0] == 31'h01080000 && o_reg_rdata[31] == $past(enable_q)
    ) else $error("control register value wrong");

    // accesses come with an idle cycle between them, so allow one here
    enable_rw_a: assert property ( // [RULE_12]
        (i_reg_wr && i_reg_addr == VC1_CTL_OFFSET && i_reg_be[3]) ##1 !i_reg_wr ##1
        (i_reg_rd && i_reg_addr == VC1_CTL_OFFSET) |=>
            o_reg_rdata[31] == $past(i_reg_wdata[31], 3)
    ) else $error("enable bit does not read back");

    access_ack_a: assert property ( // [RULE_05]
        (i_reg_rd || i_reg_wr) |=> o_reg_ack ##1 !o_reg_ack || $past(i_reg_rd || i_reg_wr)
    ) else $error("access not answered");

    ack_idle_a: assert property ( // [RULE_05]
        !(i_reg_rd || i_reg_wr) |=> !o_reg_ack
    ) else $error("answer without an access");

    rdata_hold_a: assert property ( // [RULE_05]
        !i_reg_rd |=> $stable(o_reg_rdata)
    ) else $error("read data moved without a read");

    unmapped_zero_a: assert property ( // [RULE_13]
        (i_reg_rd && i_reg_addr != VC0_STATUS_DWORD && i_reg_addr != VC1_CAP_OFFSET
            && i_reg_addr != VC1_CTL_OFFSET) |=> o_reg_rdata == 32'h0000_0000
    ) else $error("unmapped read not zero");

    ctl_hold_a: assert property ( // [RULE_13]
        (i_reg_wr && i_reg_addr == VC1_CTL_OFFSET && !i_reg_be[3]) |=> $stable(enable_q)
    ) else $error("enable bit changed without its byte lane");

    reset_value_a: assert property ( // [RULE_11]
        $rose(rst_n_sync) |-> !pending && !tsl_locked && tsl == TSL_RESET && !enable_q
    ) else $error("state not at reset value after release");

    pending_seen_c: cover property (
        (i_reg_rd && i_reg_addr == VC0_STATUS_DWORD && pending) ##1 o_reg_rdata[17]
    );
    negotiation_done_c: cover property (pending ##1 !pending);
    slot_locked_c: cover property (tsl_locked && i_reg_wr && i_reg_addr == VC1_CAP_OFFSET);
    reject_c: cover property (o_vc1_unsupported_req);
    enable_set_c: cover property (!enable_q ##1 enable_q);

endmodule : egress_vc_status_capability_regs
`default_nettype wire

// [test/vc_link_partner.sv]
// link partner model: channel zero negotiation state and channel one requests
`timescale 1ns/10ps
`default_nettype none
module vc_link_partner (
    // clock
    input  wire logic i_sys_clk,
    // negotiation state and requests toward the block
    output logic      o_fc_init_in_progress,
    output logic      o_vc0_disable_in_progress,
    output logic      o_vc1_req_valid,
    output logic      o_vc1_req_no_snoop
);
    initial begin
        o_fc_init_in_progress     = 1'b0;
        o_vc0_disable_in_progress = 1'b0;
        o_vc1_req_valid           = 1'b0;
        o_vc1_req_no_snoop        = 1'b0;
    end

    // =====================================================================
    // negotiation phase
    // =====================================================================
    // no traffic is offered while a phase runs
    task automatic negotiate(input logic dis, input int n);
        @(posedge i_sys_clk);
        if (dis) begin
            o_vc0_disable_in_progress <= 1'b1;
        end else begin
            o_fc_init_in_progress <= 1'b1;
        end
        repeat (n) @(posedge i_sys_clk);
        o_fc_init_in_progress     <= 1'b0;
        o_vc0_disable_in_progress <= 1'b0;
    endtask : negotiate

    // =====================================================================
    // channel one requests, back to back
    // =====================================================================
    task automatic requests(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            o_vc1_req_valid    <= 1'b1;
            o_vc1_req_no_snoop <= 1'($urandom_range(0, 1));
        end
        @(posedge i_sys_clk);
        o_vc1_req_valid <= 1'b0;
        // idle attribute flips so a stale value is never mistaken for a request
        o_vc1_req_no_snoop <= ~o_vc1_req_no_snoop;
    endtask : requests
endmodule : vc_link_partner
`default_nettype wire

// [test/egress_vc_status_capability_regs_tb.sv]
// self-checking bench for the egress channel status and capability registers
`timescale 1ns/10ps
`default_nettype none
module egress_vc_status_capability_regs_tb;
    import egress_vc_pkg::*;
    typedef struct packed {logic rd; logic [31:0] data; int due;} note_t;
    localparam int LIMIT = 3000;

    logic              i_sys_clk;
    logic              i_resetn;
    logic              i_reg_rd;
    logic              i_reg_wr;
    logic [ADDR_W-1:0] i_reg_addr;
    logic [3:0]        i_reg_be;
    logic [31:0]       i_reg_wdata;
    logic [31:0]       o_reg_rdata;
    logic              o_reg_ack;
    logic              fc_busy;
    logic              dis_busy;
    logic              req_valid;
    logic              req_ns;
    logic              o_pending;
    logic              o_unsup;
    logic [TSL_W-1:0]  o_tsl;
    logic [6:0]        tsl_m;
    logic              lock_m;
    logic              en_m;
    logic              run;
    logic              pend_e;
    logic              unsup_e;
    logic [31:0]       v;
    logic [11:0]       addrs[4] = '{12'h018, 12'h01c, 12'h020, 12'h024};
    note_t             notes[$];
    note_t             n;
    int                mismatches;
    int                tests_run;
    int                cycles = 0;

    egress_vc_status_capability_regs uut (
        .i_sys_clk                         (i_sys_clk),
        .i_resetn                          (i_resetn),
        .i_reg_rd                          (i_reg_rd),
        .i_reg_wr                          (i_reg_wr),
        .i_reg_addr                        (i_reg_addr),
        .i_reg_be                          (i_reg_be),
        .i_reg_wdata                       (i_reg_wdata),
        .o_reg_rdata                       (o_reg_rdata),
        .o_reg_ack                         (o_reg_ack),
        .i_fc_init_in_progress             (fc_busy),
        .i_vc0_disable_in_progress         (dis_busy),
        .o_channel_zero_negotiation_pending(o_pending),
        .i_vc1_req_valid                   (req_valid),
        .i_vc1_req_no_snoop                (req_ns),
        .o_vc1_unsupported_req             (o_unsup),
        .o_time_slot_limit                 (o_tsl)
    );

    vc_link_partner u_partner (
        .i_sys_clk                (i_sys_clk),
        .o_fc_init_in_progress    (fc_busy),
        .o_vc0_disable_in_progress(dis_busy),
        .o_vc1_req_valid          (req_valid),
        .o_vc1_req_no_snoop       (req_ns)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // =====================================================================
    // checking helpers
    // =====================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [31:0] expect_rd(input logic [11:0] a);
        case (a)
            12'h018: expect_rd = {14'h0000, fc_busy | dis_busy, 1'b0, 16'h0000};
            12'h01c: expect_rd = {8'h10, 1'b0, tsl_m, 1'b1, 7'h00, 8'h10};
            12'h020: expect_rd = {en_m, 31'h01080000};
            default: expect_rd = 32'h00000000;
        endcase
    endfunction : expect_rd

    // one access; the model follows writes as the design takes them
    task automatic access(input logic w, input logic [11:0] a, input logic [3:0] b,
                          input logic [31:0] d);
        @(posedge i_sys_clk);
        i_reg_rd    <= ~w;
        i_reg_wr    <= w;
        i_reg_addr  <= a;
        i_reg_be    <= b;
        i_reg_wdata <= d;
        notes.push_back('{rd: ~w, data: expect_rd(a), due: cycles + 2});
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        i_reg_wr <= 1'b0;
        if (w && a == 12'h01c && b[2] && !lock_m) begin
            tsl_m <= d[22:16];
        end
        if (w && a == 12'h01c && b[2]) begin
            lock_m <= 1'b1;
        end
        if (w && a == 12'h020 && b[3]) begin
            en_m <= d[31];
        end
    endtask : access

    task automatic do_reset();
        repeat (2) @(posedge i_sys_clk);
        run      <= 1'b0;
        i_resetn <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        tsl_m    <= 7'h00;
        lock_m   <= 1'b0;
        en_m     <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        run <= 1'b1;
    endtask : do_reset

    // =====================================================================
    // output watcher
    // =====================================================================
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (run) begin
            check("pending", 32'(o_pending), 32'(pend_e));
            check("unsupported", 32'(o_unsup), 32'(unsup_e));
            check("time_slot", 32'(o_tsl), 32'(tsl_m));
            if (notes.size() != 0 && notes[0].due == cycles) begin
                n = notes.pop_front();
                check("ack", 32'(o_reg_ack), 32'h1);
                if (n.rd) begin
                    check("rdata", o_reg_rdata, n.data);
                end
            end else begin
                check("idle_ack", 32'(o_reg_ack), 32'h0);
            end
        end
        pend_e  = fc_busy | dis_busy;
        unsup_e = req_valid & ~req_ns;
        // ceiling comes last so nothing runs after the verdict
        if (cycles == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        i_resetn    = 1'b0;
        i_reg_rd    = 1'b0;
        i_reg_wr    = 1'b0;
        i_reg_addr  = 12'h000;
        i_reg_be    = 4'h0;
        i_reg_wdata = 32'h00000000;
        run         = 1'b0;
        tsl_m       = 7'h00;
        lock_m      = 1'b0;
        en_m        = 1'b0;
        mismatches  = 0;
        tests_run   = 0;
        void'($urandom(32'h360aa2e3));
        do_reset();
        foreach (addrs[i]) access(1'b0, addrs[i], 4'hf, 32'h0);
        // ones everywhere, time slot lane masked off
        foreach (addrs[i]) access(1'b1, addrs[i], 4'hb, '1);
        foreach (addrs[i]) access(1'b0, addrs[i], 4'hf, 32'h0);
        v = $urandom;
        access(1'b1, 12'h01c, 4'h4, v);
        access(1'b1, 12'h01c, 4'hf, ~v);
        access(1'b0, 12'h01c, 4'hf, 32'h0);
        access(1'b1, 12'h020, 4'h8, 32'h0);
        access(1'b0, 12'h020, 4'hf, 32'h0);
        for (int k = 0; k < 2; k++) begin
            fork
                u_partner.negotiate(1'(k), 6 + $urandom_range(0, 5));
                begin
                    repeat (3) @(posedge i_sys_clk);
                    access(1'b0, 12'h018, 4'hf, 32'h0);
                end
            join
            repeat (2) @(posedge i_sys_clk);
            access(1'b0, 12'h018, 4'hf, 32'h0);
        end
        u_partner.requests(24);
        // second reset unlocks the write-once field
        do_reset();
        access(1'b0, 12'h01c, 4'hf, 32'h0);
        access(1'b1, 12'h01c, 4'h4, ~v);
        access(1'b0, 12'h01c, 4'hf, 32'h0);
        repeat (3) @(posedge i_sys_clk);
        check("open_notes", 32'(notes.size()), 32'h0);
        print_verdict();
    end
endmodule : egress_vc_status_capability_regs_tb
`default_nettype wire
